// File: logic/can_msg_status.sv
// Message object status and standard identifier tag registers with the
// frame checker that raises the status events.
// Assumes bit_sample pulses once per bit at the sample point, can_rx and
// tx_bit are that bit's bus and driven levels, tx_active marks own frames.
`timescale 1ns/1ps
`default_nettype none
module can_msg_status (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata_q,
  input wire logic bit_sample,
  input wire logic can_rx,
  input wire logic tx_active,
  input wire logic tx_bit,
  output logic tx_request_q,
  output logic [3:0] tx_object_q,
  output logic ack_dominant_q,
  output logic irq_request_q
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0] page_q;
  logic [7:0] status_q [can_status_pkg::NUM_OBJ];
  logic [7:0] control_q [can_status_pkg::NUM_OBJ];
  logic [7:0] id_high_q [can_status_pkg::NUM_OBJ];
  logic [7:0] id_low_q [can_status_pkg::NUM_OBJ];
  logic [7:0] id_unused_q [can_status_pkg::NUM_OBJ];
  can_status_pkg::frame_state_e state_q, state_d;
  logic [6:0] cnt_q, cnt_d;
  logic [2:0] run_q;
  logic last_q;
  logic [10:0] id_q;
  logic rtr_q;
  logic [3:0] dlc_q;
  logic [14:0] rx_crc_q;
  logic lost_q;
  logic match_ok_q;
  logic [3:0] match_idx_q;
  logic [14:0] crc_val;
  logic [14:0] tx_en_vec, rx_hit_vec;
  logic tx_any, hit_any;
  logic [3:0] tx_idx, hit_idx;
  logic irq_any;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  wire [3:0] sel = page_q[7:4];
  wire sel_ok = sel <= can_status_pkg::OBJ_MAX;
  wire wr_page = sfr_wr && sfr_addr == can_status_pkg::ADDR_PAGE;
  wire wr_status = sfr_wr && sel_ok && sfr_addr == can_status_pkg::ADDR_STATUS;
  wire wr_control = sfr_wr && sel_ok && sfr_addr == can_status_pkg::ADDR_CONTROL;
  wire wr_high = sfr_wr && sel_ok && sfr_addr == can_status_pkg::ADDR_ID_HIGH;
  wire wr_low = sfr_wr && sel_ok && sfr_addr == can_status_pkg::ADDR_ID_LOW;
  wire wr_unused = sfr_wr && sel_ok && sfr_addr == can_status_pkg::ADDR_ID_UNUSED;
  wire [7:0] rd_obj =
    !sel_ok ? 8'h00 :
    sfr_addr == can_status_pkg::ADDR_STATUS ? status_q[sel] :
    sfr_addr == can_status_pkg::ADDR_CONTROL ? control_q[sel] :
    sfr_addr == can_status_pkg::ADDR_ID_HIGH ? id_high_q[sel] :
    sfr_addr == can_status_pkg::ADDR_ID_LOW ? id_low_q[sel] :
    sfr_addr == can_status_pkg::ADDR_ID_UNUSED ? id_unused_q[sel] : 8'h00;
  wire [7:0] rd_data = sfr_addr == can_status_pkg::ADDR_PAGE ? page_q : rd_obj;

  ////////////////////////////////////////////////////////////////////////////
  // Bit level checks

  wire is_idle = state_q == can_status_pkg::FR_IDLE;
  wire is_wait = state_q == can_status_pkg::FR_WAIT;
  wire is_crc_del = state_q == can_status_pkg::FR_CRC_DEL;
  wire is_ack_slot = state_q == can_status_pkg::FR_ACK_SLOT;
  wire in_stuff = state_q >= can_status_pkg::FR_ID && state_q <= can_status_pkg::FR_CRC;
  wire in_crc_calc = state_q >= can_status_pkg::FR_ID && state_q <= can_status_pkg::FR_DATA;
  wire arb_field = state_q == can_status_pkg::FR_ID || state_q == can_status_pkg::FR_RTR;
  wire fixed_form = is_crc_del || state_q == can_status_pkg::FR_ACK_DEL ||
    state_q == can_status_pkg::FR_EOF;
  wire tx_role = tx_active && !lost_q;
  wire stuff_bit = bit_sample && (in_stuff || is_crc_del) && run_q == can_status_pkg::STUFF_LIMIT;
  wire take = bit_sample && !stuff_bit && !is_wait;
  wire stuff_err = stuff_bit && can_rx == last_q;
  wire arb_lost = bit_sample && tx_role && arb_field && tx_bit && !can_rx;
  wire bit_err = bit_sample && tx_role && !is_idle && !is_wait && !is_ack_slot &&
    can_rx != tx_bit && !arb_lost;
  wire form_err = take && fixed_form && !can_rx;
  wire ack_err = take && tx_role && is_ack_slot && can_rx;
  wire crc_err = take && !tx_role && is_crc_del && rx_crc_q != crc_val;
  wire any_err = stuff_err || bit_err || form_err || ack_err || crc_err;
  wire eof_last = state_q == can_status_pkg::FR_EOF && cnt_q == can_status_pkg::EOF_BITS - 7'h01;
  wire frame_ok = take && eof_last && can_rx && !any_err;

  wire [3:0] dlc_in = {dlc_q[2:0], can_rx};
  wire [3:0] dlc_clip = dlc_q > can_status_pkg::DLC_MAX ? can_status_pkg::DLC_MAX : dlc_q;
  wire [6:0] data_bits = {dlc_clip, 3'h0};

  can_crc15 u_crc (
    .clock(clock),
    .rst_n(rst_n),
    .clear(is_idle),
    .shift_en(take && in_crc_calc),
    .bit_in(can_rx),
    .crc_q(crc_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame field sequencer, standard format only

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (bit_sample) begin
      if (is_wait) begin
        if (!can_rx) begin
          cnt_d = 7'h00;
        end else if (cnt_q == can_status_pkg::IDLE_RECESSIVE - 7'h01) begin
          state_d = can_status_pkg::FR_IDLE;
          cnt_d = 7'h00;
        end else begin
          cnt_d = cnt_q + 7'h01;
        end
      end else if (any_err) begin
        state_d = can_status_pkg::FR_WAIT;
        cnt_d = 7'h00;
      end else if (!stuff_bit) begin
        cnt_d = cnt_q + 7'h01;
        case (state_q)
          can_status_pkg::FR_IDLE: begin
            cnt_d = 7'h00;
            if (!can_rx) begin
              state_d = can_status_pkg::FR_ID;
            end
          end
          can_status_pkg::FR_ID: begin
            if (cnt_q == can_status_pkg::ID_BITS - 7'h01) begin
              state_d = can_status_pkg::FR_RTR;
            end
          end
          can_status_pkg::FR_RTR: state_d = can_status_pkg::FR_IDE;
          // Extended frames are not decoded here: wait for bus idle
          can_status_pkg::FR_IDE: begin
            state_d = can_rx ? can_status_pkg::FR_WAIT : can_status_pkg::FR_R0;
          end
          can_status_pkg::FR_R0: state_d = can_status_pkg::FR_DLC;
          can_status_pkg::FR_DLC: begin
            if (cnt_q == can_status_pkg::DLC_BITS - 7'h01) begin
              state_d = (rtr_q || dlc_in == 4'h0) ? can_status_pkg::FR_CRC :
                can_status_pkg::FR_DATA;
            end
          end
          can_status_pkg::FR_DATA: begin
            if (cnt_q == data_bits - 7'h01) begin
              state_d = can_status_pkg::FR_CRC;
            end
          end
          can_status_pkg::FR_CRC: begin
            if (cnt_q == can_status_pkg::CRC_BITS - 7'h01) begin
              state_d = can_status_pkg::FR_CRC_DEL;
            end
          end
          can_status_pkg::FR_CRC_DEL: state_d = can_status_pkg::FR_ACK_SLOT;
          can_status_pkg::FR_ACK_SLOT: state_d = can_status_pkg::FR_ACK_DEL;
          can_status_pkg::FR_ACK_DEL: state_d = can_status_pkg::FR_EOF;
          can_status_pkg::FR_EOF: begin
            if (eof_last) begin
              state_d = can_status_pkg::FR_IDLE;
            end
          end
          default: state_d = can_status_pkg::FR_WAIT;
        endcase
        if (state_d != state_q) begin
          cnt_d = 7'h00;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= can_status_pkg::FR_WAIT;
      cnt_q <= 7'h00;
      run_q <= 3'h0;
      last_q <= 1'b1;
      lost_q <= 1'b0;
      ack_dominant_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (bit_sample) begin
        last_q <= can_rx;
        run_q <= (in_stuff && !stuff_bit && can_rx == last_q) ? run_q + 3'h1 : 3'h1;
        lost_q <= is_idle ? 1'b0 : (lost_q || arb_lost);
        // Receivers acknowledge any standard frame whose CRC and delimiter are good
        ack_dominant_q <= take && is_crc_del && !any_err && !tx_role;
      end
    end
  end

  // Destuffed field capture
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      id_q <= 11'h000;
      rtr_q <= 1'b0;
      dlc_q <= 4'h0;
      rx_crc_q <= 15'h0000;
      match_ok_q <= 1'b0;
      match_idx_q <= 4'h0;
    end else if (take) begin
      if (state_q == can_status_pkg::FR_ID) id_q <= {id_q[9:0], can_rx};
      if (state_q == can_status_pkg::FR_RTR) rtr_q <= can_rx;
      if (state_q == can_status_pkg::FR_DLC) dlc_q <= dlc_in;
      if (state_q == can_status_pkg::FR_CRC) rx_crc_q <= {rx_crc_q[13:0], can_rx};
      if (state_q == can_status_pkg::FR_RTR) begin
        match_ok_q <= hit_any && !tx_role;
        match_idx_q <= hit_idx;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Object selection: lowest index wins for transmit and for receive hits

  always_comb begin
    tx_any = 1'b0;
    hit_any = 1'b0;
    tx_idx = 4'h0;
    hit_idx = 4'h0;
    irq_any = 1'b0;
    for (int i = 0; i < can_status_pkg::NUM_OBJ; i++) begin
      tx_en_vec[i] = control_q[i][7:6] == can_status_pkg::CONF_TX &&
        !control_q[i][can_status_pkg::CTL_EXT_SEL];
      rx_hit_vec[i] = control_q[i][can_status_pkg::CTL_CONF_HI] &&
        !control_q[i][can_status_pkg::CTL_EXT_SEL] &&
        {id_high_q[i], id_low_q[i][7:5]} == id_q;
      irq_any = irq_any || |(status_q[i] & can_status_pkg::IRQ_FLAGS);
    end
    for (int i = can_status_pkg::NUM_OBJ - 1; i >= 0; i--) begin
      if (tx_en_vec[i]) begin
        tx_any = 1'b1;
        tx_idx = 4'(i);
      end
      if (rx_hit_vec[i]) begin
        hit_any = 1'b1;
        hit_idx = 4'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status events

  wire [3:0] ev_obj = tx_role ? tx_object_q : match_idx_q;
  wire ev_ok = tx_role || match_ok_q;
  wire rx_fin = frame_ok && !tx_role;
  wire [7:0] ev_set = {
    rx_fin && control_q[ev_obj][3:0] != dlc_q,
    frame_ok && tx_role,
    rx_fin,
    bit_err,
    stuff_err,
    crc_err,
    form_err,
    ack_err
  };

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      page_q <= can_status_pkg::PAGE_RESET;
      sfr_rdata_q <= 8'h00;
      tx_request_q <= 1'b0;
      tx_object_q <= 4'h0;
      irq_request_q <= 1'b0;
    end else begin
      if (wr_page) page_q <= sfr_wdata;
      if (sfr_rd) sfr_rdata_q <= rd_data;
      irq_request_q <= irq_any;
      // The choice only moves between frames
      if (is_idle || is_wait) begin
        tx_request_q <= tx_any;
        tx_object_q <= tx_idx;
      end
    end
  end

  // Hardware sets win over a same-cycle software write
  always_ff @(posedge clock) begin
    for (int i = 0; i < can_status_pkg::NUM_OBJ; i++) begin
      if (!rst_n) begin
        status_q[i] <= can_status_pkg::STATUS_RESET;
        control_q[i] <= can_status_pkg::CONTROL_RESET;
      end else begin
        if (wr_status && sel == 4'(i)) begin
          status_q[i] <= sfr_wdata | ((ev_ok && ev_obj == 4'(i)) ? ev_set : 8'h00);
        end else if (ev_ok && ev_obj == 4'(i)) begin
          status_q[i] <= status_q[i] | ev_set;
        end
        if (frame_ok && ev_ok && ev_obj == 4'(i)) begin
          control_q[i][3:0] <= dlc_q;
          if (tx_role || control_q[i][7:6] == can_status_pkg::CONF_RX) begin
            control_q[i][7:6] <= can_status_pkg::CONF_OFF;
          end
          control_q[i][5:4] <= wr_control && sel == 4'(i) ? sfr_wdata[5:4] : control_q[i][5:4];
        end else if (wr_control && sel == 4'(i)) begin
          control_q[i] <= sfr_wdata;
        end
      end
    end
  end

  // Tag storage has no reset; reserved bits keep whatever was written
  always_ff @(posedge clock) begin
    for (int i = 0; i < can_status_pkg::NUM_OBJ; i++) begin
      if (wr_high && sel == 4'(i)) id_high_q[i] <= sfr_wdata;
      if (wr_low && sel == 4'(i)) id_low_q[i] <= sfr_wdata;
      if (wr_unused && sel == 4'(i)) id_unused_q[i] <= sfr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [3:0] ev_obj_past_q;
  always_ff @(posedge clock) begin
    ev_obj_past_q <= ev_obj;
  end
  wire [14:0] low_mask = 15'((15'h0001 << tx_object_q) - 15'h0001);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_rx_finish;
    rx_fin && match_ok_q;
  endsequence
  sequence s_tx_finish;
    frame_ok && tx_role;
  endsequence

  a_len_warning: assert property (s_rx_finish ##0 control_q[ev_obj][3:0] != dlc_q
    |=> status_q[ev_obj_past_q][can_status_pkg::ST_LEN_WARN])
    else $error("length mismatch not flagged");
  a_len_overwrite: assert property (s_rx_finish |=> control_q[ev_obj_past_q][3:0] == $past(dlc_q))
    else $error("length code not updated");
  a_tx_done: assert property (s_tx_finish |=> status_q[ev_obj_past_q][can_status_pkg::ST_TX_DONE]
    && control_q[ev_obj_past_q][7:6] == can_status_pkg::CONF_OFF)
    else $error("transmit completion lost");
  a_tx_lowest: assert property (tx_request_q && is_idle && $past(is_idle) && $stable(tx_en_vec)
    |-> tx_en_vec[tx_object_q] && (tx_en_vec & low_mask) == 15'h0000)
    else $error("transmit object not lowest");
  a_rx_done: assert property (s_rx_finish |=> status_q[ev_obj_past_q][can_status_pkg::ST_RX_DONE])
    else $error("receive completion lost");
  a_bit_err_cause: assert property (bit_err |-> tx_role && can_rx != tx_bit && !is_ack_slot
    ##1 state_q == can_status_pkg::FR_WAIT)
    else $error("bit error without cause");
  a_arb_exempt: assert property (arb_lost |-> !bit_err ##1 lost_q)
    else $error("arbitration loss flagged as bit error");
  a_stuff_err: assert property (stuff_err |-> run_q == can_status_pkg::STUFF_LIMIT
    && (in_stuff || is_crc_del))
    else $error("stuff error without six equal bits");
  a_crc_err: assert property (crc_err |-> is_crc_del && rx_crc_q != crc_val
    ##1 status_q[ev_obj_past_q][can_status_pkg::ST_CRC_ERR] || !$past(match_ok_q))
    else $error("CRC error not recorded");
  a_form_err: assert property (take && fixed_form && !can_rx |-> form_err
    ##1 state_q == can_status_pkg::FR_WAIT)
    else $error("form violation missed");
  a_ack_err: assert property (take && tx_role && is_ack_slot && can_rx |=>
    status_q[ev_obj_past_q][can_status_pkg::ST_ACK_ERR])
    else $error("missing acknowledge not flagged");
  a_page_read: assert property (sfr_rd && sel_ok && sfr_addr == can_status_pkg::ADDR_STATUS
    |=> sfr_rdata_q == $past(status_q[sel]))
    else $error("status read not from selected object");

endmodule
`default_nettype wire

// File: logic/can_status_pkg.sv
// Constants for the message object status and standard identifier tag block.
// Assumes an 8-bit special function register port and a bit-sampled CAN line.
// Summary of operation
// - Status byte: warning, tx, rx, five error flags
// - Received length differs: set length mismatch warning
// - Received length code always overwrites stored length
// - Finished transmission sets transmit done flag
// - Lowest enabled object index transmits first
// - Finished reception sets receive done flag
// - Lowest matching object index is updated
// - Own transmission: sent versus seen mismatch is error
// - No bit error in arbitration or ack slot; here arbitration exempts only a sent recessive seen dominant
// - Receiver computes CRC over destuffed frame
// - CRC mismatch sets CRC error flag
// - Broken delimiters or end field: form error
// - Listed flags raise interrupt request to processor
// - High tag register holds identifier bits 10..3
// - Low tag register holds bits 2..0, rest reserved
// - Third tag register fully reserved
// - Reserved tag bits read undefined, never write ones
// - Tag registers undefined after reset
// - Page object number selects the object shown
// - Extended select picks 11 or 29 bit identifier; here a set select keeps the object out of transmit and receive
package can_status_pkg;

  localparam int NUM_OBJ = 15;
  localparam logic [3:0] OBJ_MAX = 4'hE;

  // Register addresses
  localparam logic [7:0] ADDR_PAGE = 8'hB1;
  localparam logic [7:0] ADDR_STATUS = 8'hB2;
  localparam logic [7:0] ADDR_CONTROL = 8'hB3;
  localparam logic [7:0] ADDR_ID_HIGH = 8'hBC;
  localparam logic [7:0] ADDR_ID_LOW = 8'hBD;
  localparam logic [7:0] ADDR_ID_UNUSED = 8'hBE;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Status bit positions
  localparam int ST_LEN_WARN = 7;
  localparam int ST_TX_DONE = 6;
  localparam int ST_RX_DONE = 5;
  localparam int ST_BIT_ERR = 4;
  localparam int ST_STUFF_ERR = 3;
  localparam int ST_CRC_ERR = 2;
  localparam int ST_FORM_ERR = 1;
  localparam int ST_ACK_ERR = 0;
  localparam logic [7:0] IRQ_FLAGS = 8'h7B;

  // Control byte fields: configuration 7..6, extended select 4, length 3..0
  localparam int CTL_CONF_HI = 7;
  localparam int CTL_CONF_LO = 6;
  localparam int CTL_EXT_SEL = 4;
  localparam logic [1:0] CONF_OFF = 2'h0;
  localparam logic [1:0] CONF_TX = 2'h1;
  localparam logic [1:0] CONF_RX = 2'h2;
  localparam logic [1:0] CONF_RX_BUF = 2'h3;
  localparam int TAG_LOW_LSB = 5;

  // Frame field lengths in bits, idle and stuff run lengths, length code limit and CRC polynomial
  localparam logic [6:0] ID_BITS = 7'h0B;
  localparam logic [6:0] DLC_BITS = 7'h04;
  localparam logic [6:0] CRC_BITS = 7'h0F;
  localparam logic [6:0] EOF_BITS = 7'h07;
  localparam logic [6:0] IDLE_RECESSIVE = 7'h0B;
  localparam logic [2:0] STUFF_LIMIT = 3'h5;
  localparam logic [3:0] DLC_MAX = 4'h8;
  localparam logic [14:0] CRC_POLY = 15'h4599;

  typedef enum logic [3:0] {
    FR_IDLE = 4'h0,
    FR_ID = 4'h1,
    FR_RTR = 4'h2,
    FR_IDE = 4'h3,
    FR_R0 = 4'h4,
    FR_DLC = 4'h5,
    FR_DATA = 4'h6,
    FR_CRC = 4'h7,
    FR_CRC_DEL = 4'h8,
    FR_ACK_SLOT = 4'h9,
    FR_ACK_DEL = 4'hA,
    FR_EOF = 4'hB,
    FR_WAIT = 4'hC
  } frame_state_e;

endpackage

// File: logic/can_crc15.sv
// Fifteen-bit CAN CRC accumulator, one destuffed bit per enable.
// Assumes the caller clears it before the start of each frame.
`timescale 1ns/1ps
`default_nettype none
module can_crc15 (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic shift_en,
  input wire logic bit_in,
  output logic [14:0] crc_q
);

  wire feedback = bit_in ^ crc_q[14];
  wire [14:0] crc_d = {crc_q[13:0], 1'b0} ^ (feedback ? can_status_pkg::CRC_POLY : 15'h0000);

  always_ff @(posedge clock) begin
    if (!rst_n || clear) begin
      crc_q <= 15'h0000;
    end else if (shift_en) begin
      crc_q <= crc_d;
    end
  end

endmodule
`default_nettype wire

// File: verification/can_node_model.sv
// Behavioural model of the other nodes on the CAN bus: paces bit samples
// and sends standard frames bit by bit. Assumes the device acks as receiver.
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
  input wire logic clock,
  input wire logic ack_dominant_q,
  output logic bit_sample,
  output logic can_rx
);
  logic line_q;
  logic [1:0] phase;
  logic bits[$];
  int ack_count;

  // Wired-and bus with a recessive pull-up when nobody drives
  assign can_rx = line_q & ~ack_dominant_q;

  initial begin
    bit_sample = 1'b0;
    line_q = 1'b1;
    phase = 2'h0;
    ack_count = 0;
    forever begin
      @(posedge clock) #1;
      phase = phase + 2'h1;
      bit_sample = (phase == 2'h2);
      if (bit_sample && ack_dominant_q) ack_count++;
      if (phase == 2'h0) begin
        line_q = (bits.size() > 0) ? bits.pop_front() : 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode 1 spoils the CRC, 2 breaks stuffing in data, 3 a dominant EOF bit, 4 acks
  task automatic send_frame(input logic [10:0] id, input logic [3:0] data_length_code_field,
      input logic [63:0] data, input int mode);
    logic u[$];
    logic [14:0] crc;
    logic nxt;
    logic last;
    int run;
    int nbytes;
    nbytes = (data_length_code_field > 4'h8) ? 8 : int'(data_length_code_field);
    crc = 15'h0;
    u.push_back(1'b0);
    for (int i = 10; i >= 0; i--) u.push_back(id[i]);
    repeat (3) u.push_back(1'b0);
    for (int i = 3; i >= 0; i--) u.push_back(data_length_code_field[i]);
    for (int i = 0; i < nbytes * 8; i++) u.push_back(data[63 - i]);
    foreach (u[i]) begin
      nxt = u[i] ^ crc[14];
      crc = {crc[13:0], 1'b0} ^ (nxt ? can_status_pkg::CRC_POLY : 15'h0);
    end
    if (mode == 1) crc[0] = ~crc[0];
    for (int i = 14; i >= 0; i--) u.push_back(crc[i]);
    run = 0;
    last = 1'b1;
    foreach (u[i]) begin
      bits.push_back(u[i]);
      run = (u[i] == last) ? run + 1 : 1;
      last = u[i];
      if (run == 5) begin
        last = (mode == 2 && i > 18) ? last : ~last;
        bits.push_back(last);
        run = 1;
      end
    end
    bits.push_back(1'b1);
    bits.push_back(mode != 4);
    bits.push_back(1'b1);
    bits.push_back(mode != 3);
    repeat (17) bits.push_back(1'b1);
    while (bits.size() > 0) @(posedge clock);
    repeat (8) @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking testbench for the message object status and tag block.
// Assumes the node model is the only other party on the bus.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock, rst_n, sfr_wr, sfr_rd, bit_sample, can_rx, tx_active, tx_bit;
  logic tx_request_q, ack_dominant_q, irq_request_q;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q;
  logic [3:0] tx_object_q;
  int fail_count, cmp_count;

  // The own transmitter echoes what the model puts on the line
  assign tx_bit = tx_active ? u_can_node_model.line_q : 1'b1;

  can_msg_status u_can_msg_status (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
    .bit_sample(bit_sample), .can_rx(can_rx), .tx_active(tx_active), .tx_bit(tx_bit),
    .tx_request_q(tx_request_q), .tx_object_q(tx_object_q),
    .ack_dominant_q(ack_dominant_q), .irq_request_q(irq_request_q));
  can_node_model u_can_node_model (.clock(clock), .ack_dominant_q(ack_dominant_q),
    .bit_sample(bit_sample), .can_rx(can_rx));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clock) #1 sfr_wr = 1'b0;
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock) #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clock) #1 sfr_rd = 1'b0;
    chk(name, exp, sfr_rdata_q);
  endtask
  task automatic close_out;
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk("page", 8'hB1, 8'h00);
    rchk("status", 8'hB2, 8'h00);
    rchk("unmapped", 8'hA0, 8'h00);
    chk("irq", 8'h00, {7'h0, irq_request_q});
  endtask
  task automatic t_tags;
    for (int k = 0; k < 15; k += 14) begin
      wr(8'hB1, {k[3:0], 4'h0});
      wr(8'hBC, 8'hC3 ^ k[7:0]);
      wr(8'hBD, 8'h60);
    end
    for (int k = 0; k < 15; k += 14) begin
      wr(8'hB1, {k[3:0], 4'h0});
      rchk("tag_high", 8'hBC, 8'hC3 ^ k[7:0]);
      rchk("tag_low", 8'hBD, 8'h60);
    end
    wr(8'hB1, 8'hF0);
    rchk("no_object", 8'hBC, 8'h00);
  endtask
  task automatic t_rx;
    for (int k = 1; k < 3; k++) begin
      wr(8'hB1, {k[3:0], 4'h0});
      wr(8'hBC, 8'h5A);
      wr(8'hBD, 8'hA0);
      wr(8'hB3, 8'h84);
    end
    u_can_node_model.send_frame(11'h2D5, 4'h2, {16'h1234, 48'h0}, 0);
    wr(8'hB1, 8'h10);
    rchk("rx_status", 8'hB2, 8'hA0);
    rchk("rx_length", 8'hB3, 8'h02);
    chk("irq", 8'h01, {7'h0, irq_request_q});
    chk("rx_ack", 8'h01, 8'(u_can_node_model.ack_count));
    wr(8'hB2, 8'h00);
    wr(8'hB1, 8'h20);
    rchk("second_hit", 8'hB2, 8'h00);
  endtask
  task automatic err_frame(input string name, input int mode, input logic [7:0] exp,
      input logic irq);
    u_can_node_model.send_frame(11'h2D5, 4'h1, 64'h0, mode);
    wr(8'hB1, 8'h20);
    rchk(name, 8'hB2, exp);
    chk("irq", {7'h0, irq}, {7'h0, irq_request_q});
    wr(8'hB2, 8'h00);
  endtask
  task automatic t_tx;
    wr(8'hB1, 8'h00);
    wr(8'hB3, 8'h51);
    wr(8'hB1, 8'h50);
    wr(8'hB3, 8'h41);
    wr(8'hB1, 8'h30);
    wr(8'hB3, 8'h41);
    repeat (3) @(posedge clock);
    #1;
    chk("tx_req", 8'h01, {7'h0, tx_request_q});
    chk("tx_obj", 8'h03, {4'h0, tx_object_q});
    tx_active = 1'b1;
    u_can_node_model.send_frame(11'h155, 4'h1, 64'h0, 0);
    tx_active = 1'b0;
    rchk("ack_err", 8'hB2, 8'h01);
    wr(8'hB2, 8'h00);
    tx_active = 1'b1;
    u_can_node_model.send_frame(11'h155, 4'h1, 64'h0, 4);
    tx_active = 1'b0;
    rchk("tx_done", 8'hB2, 8'h40);
    rchk("tx_conf", 8'hB3, 8'h01);
    chk("tx_no_ack", 8'h02, 8'(u_can_node_model.ack_count));
    wr(8'hB2, 8'h00);
    wr(8'hB3, 8'h00);
    repeat (3) @(posedge clock);
    #1;
    chk("tx_next", 8'h05, {4'h0, tx_object_q});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    close_out();
  end
  initial begin
    fail_count = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    tx_active = 1'b0;
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b1;
    t_reset();
    t_tags();
    t_rx();
    err_frame("crc_err", 1, 8'h04, 1'b0);
    err_frame("stuff_err", 2, 8'h08, 1'b1);
    err_frame("form_err", 3, 8'h02, 1'b1);
    t_tx();
    close_out();
  end
endmodule
`default_nettype wire
